//--- verilog/hmcg_top.sv
// halt mode controller: cpu clock gate, port hold, peripheral clocks
//
// Behaviour
// - executing halt while on the subsystem clock gates off the cpu clock.
// - the port output latch keeps its pre-halt value throughout halt.
// - with the high-speed oscillator off, timer a counts only on its pin.
// - hs off: both async ports run only when clocked from a running timer a.
// - hs off: the clocked serial port shifts only from the external shift clock.
// - an option bit allows stopping the oscillator; then watchdog halts.
// - the internal oscillator is stopped only if allowed and requested.
// - hs on, internal off: the watch timer runs only from the hs clock.
// - hs off: the watch timer runs only from the subsystem clock.
// - an unmasked interrupt ends halt after 8 or 2 clocks of wait.
// - reset ends halt and restarts from the reset vector.
`timescale 1ns/1ps
`include "hmcg_regs.svh"
module hmcg_top #(
  parameter int PORT_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic halt_exec,
  input wire logic cpu_on_subclk,
  input wire logic hs_osc_run,
  input wire logic opt_iosc_soft_stop,
  input wire logic sw_iosc_stop,
  input wire logic irq_unmasked,
  input wire logic irq_enable,
  input wire logic port_wr,
  input wire logic [PORT_W-1:0] port_wr_data,
  input wire hmcg_pkg::hmcg_sel_type periph_sel,
  output logic cpu_clk_en,
  output logic halted,
  output logic iosc_run,
  output logic [PORT_W-1:0] port_latch,
  output hmcg_pkg::hmcg_en_type periph_en,
  output logic vector_take,
  output logic resume_next,
  output logic reset_vector
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    // controller state and latched halt context
    hmcg_pkg::hmcg_state_type st;
    logic loaded;
    logic opt;
    logic halt_sub;
    // wake wait
    logic vec;
    logic [3:0] cnt;
    // port latch and registered outputs
    logic [PORT_W-1:0] port;
    logic cpu_en;
    logic iosc_run;
    hmcg_pkg::hmcg_en_type en;
    logic vec_pulse;
    logic next_pulse;
    logic rst_vec;
    logic hlt;
  } hmcg_reg_type;

  hmcg_reg_type r_q;
  hmcg_reg_type r_d;
  hmcg_pkg::hmcg_src_type src;
  hmcg_pkg::hmcg_en_type en_next;
  logic iosc_stop;
  // decoded requests
  logic in_halt;
  logic opt_take;
  logic port_take;
  logic halt_take;
  logic wake_take;
  logic wait_done;
  logic [3:0] wait_load;

  // ****************************************
  // peripheral gating
  // ****************************************
  always_comb begin
    // a stop request counts only where the option allows it
    iosc_stop = r_q.opt & sw_iosc_stop;
    src.halt_sub = in_halt & r_q.halt_sub;
    src.halted = in_halt;
    // oscillators are seen live; the halt context is latched
    src.hs_run = hs_osc_run;
    src.iosc_stopped = iosc_stop;
    src.opt_stoppable = r_q.opt;
  end

  hmcg_periph_gate u_gate (
    .src(src),
    .sel(periph_sel),
    .en(en_next)
  );

  // ****************************************
  // request decode
  // ****************************************
  always_comb begin
    in_halt = (r_q.st != hmcg_pkg::HMCG_RUN);
    // the option setting is taken once after reset, like a fuse
    opt_take = ~r_q.loaded;
    // cpu writes only reach the latch while the cpu still runs
    port_take = ~in_halt & port_wr;
    halt_take = ~in_halt & halt_exec;
    // only the halt state listens; the wake wait is not restarted
    wake_take = (r_q.st == hmcg_pkg::HMCG_HALT) & irq_unmasked;
    wait_done = (r_q.st == hmcg_pkg::HMCG_WAKE)
              & (r_q.cnt == `HMCG_CNT_RST);
    // the count runs down to zero, so it starts one below the wait
    if (irq_enable) begin
      wait_load = `HMCG_WAIT_VEC - 4'h1;
    end else begin
      wait_load = `HMCG_WAIT_NOVEC - 4'h1;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    r_d = r_q;
    // wake and reset marks are single-cycle pulses
    r_d.vec_pulse = 1'b0;
    r_d.next_pulse = 1'b0;
    r_d.rst_vec = 1'b0;
    // peripheral enables are registered one stage after the sources
    r_d.en = en_next;
    r_d.iosc_run = ~iosc_stop;
    if (opt_take) begin
      r_d.loaded = 1'b1;
      r_d.opt = opt_iosc_soft_stop;
    end
    case (r_q.st)
      hmcg_pkg::HMCG_RUN: begin
        if (port_take) begin
          r_d.port = port_wr_data;
        end
        // halt context is captured at the instruction edge
        if (halt_take) begin
          r_d.st = hmcg_pkg::HMCG_HALT;
          r_d.halt_sub = cpu_on_subclk;
          r_d.cpu_en = 1'b0;
        end
      end
      hmcg_pkg::HMCG_HALT: begin
        // port writes are ignored: the latch stays frozen
        if (wake_take) begin
          r_d.st = hmcg_pkg::HMCG_WAKE;
          r_d.vec = irq_enable;
          r_d.cnt = wait_load;
        end
      end
      hmcg_pkg::HMCG_WAKE: begin
        // the cpu clock stays off for the whole wait
        if (wait_done) begin
          r_d.st = hmcg_pkg::HMCG_RUN;
          r_d.halt_sub = 1'b0;
          r_d.cpu_en = 1'b1;
          // one pulse tells the cpu how to resume
          r_d.vec_pulse = r_q.vec;
          r_d.next_pulse = ~r_q.vec;
        end else begin
          r_d.cnt = r_q.cnt - 4'h1;
        end
      end
      default: begin
        // an illegal code recovers to run with the cpu clock on
        r_d.st = hmcg_pkg::HMCG_RUN;
        r_d.halt_sub = 1'b0;
        r_d.cpu_en = 1'b1;
        r_d.cnt = `HMCG_CNT_RST;
      end
    endcase
    // halted is kept in a flop so the output needs no decode
    r_d.hlt = (r_d.st != hmcg_pkg::HMCG_RUN);
  end

  // ****************************************
  // registers
  // ****************************************
  // synchronous reset, also the external reset that ends halt
  always_ff @(posedge clk) begin
    if (rst) begin
      r_q.st <= hmcg_pkg::HMCG_RUN;
      r_q.loaded <= 1'b0;
      r_q.opt <= 1'b0;
      r_q.halt_sub <= 1'b0;
      r_q.vec <= 1'b0;
      r_q.cnt <= `HMCG_CNT_RST;
      r_q.port <= PORT_W'(`HMCG_PORT_RST);
      r_q.cpu_en <= 1'b1;
      r_q.iosc_run <= 1'b1;
      r_q.en <= '1;
      r_q.vec_pulse <= 1'b0;
      r_q.next_pulse <= 1'b0;
      r_q.rst_vec <= 1'b1;
      r_q.hlt <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb begin
    // every output is a straight copy of a register
    cpu_clk_en = r_q.cpu_en;
    halted = r_q.hlt;
    iosc_run = r_q.iosc_run;
    port_latch = r_q.port;
    periph_en = r_q.en;
    vector_take = r_q.vec_pulse;
    resume_next = r_q.next_pulse;
    reset_vector = r_q.rst_vec;
  end

endmodule

//--- common/hmcg_regs.svh
// constants of the halt mode clock gating block
`ifndef HMCG_REGS_SVH
`define HMCG_REGS_SVH

// ****************************************
// resumption waits, in cpu clocks
// ****************************************
`define HMCG_WAIT_VEC 4'h8
`define HMCG_WAIT_NOVEC 4'h2

// ****************************************
// reset values
// ****************************************
`define HMCG_PORT_RST 8'h00
`define HMCG_CNT_RST 4'h0

`endif

//--- common/hmcg_pkg.sv
// types of the halt mode clock gating block
package hmcg_pkg;

  // ****************************************
  // controller states
  // ****************************************
  typedef enum logic [1:0] {
    HMCG_RUN  = 2'b00,
    HMCG_HALT = 2'b01,
    HMCG_WAKE = 2'b10
  } hmcg_state_type;

  // ****************************************
  // peripheral clock selections
  // ****************************************
  typedef struct packed {
    logic ta_src_ext;
    logic ta_running;
    logic uart_a_from_ta;
    logic uart_b_from_ta;
    logic csi_ext_clk;
    logic wt_src_hs;
    logic wt_src_sub;
  } hmcg_sel_type;

  // ****************************************
  // peripheral clock enables
  // ****************************************
  typedef struct packed {
    logic tmr16;
    logic tmr_a;
    logic uart_a;
    logic uart_b;
    logic csi;
    logic wdt;
    logic watch;
    logic clk_mon;
  } hmcg_en_type;

  // ****************************************
  // clock source status seen in halt
  // ****************************************
  typedef struct packed {
    logic halt_sub;
    logic halted;
    logic hs_run;
    logic iosc_stopped;
    logic opt_stoppable;
  } hmcg_src_type;

endpackage

//--- verilog/hmcg_periph_gate.sv
// peripheral clock enables as a function of halt and clock sources
`timescale 1ns/1ps
module hmcg_periph_gate (
  input wire hmcg_pkg::hmcg_src_type src,
  input wire hmcg_pkg::hmcg_sel_type sel,
  output hmcg_pkg::hmcg_en_type en
);

  logic hs_off;
  logic iosc_off;

  always_comb begin
    hs_off = src.halt_sub & ~src.hs_run;
    iosc_off = src.halt_sub & src.iosc_stopped;
    en = '1;
    en.tmr16 = ~hs_off;
    if (hs_off) begin
      en.tmr_a = sel.ta_src_ext;
      en.uart_a = sel.uart_a_from_ta & sel.ta_src_ext & sel.ta_running;
      en.uart_b = sel.uart_b_from_ta & sel.ta_src_ext & sel.ta_running;
      en.csi = sel.csi_ext_clk;
      en.watch = sel.wt_src_sub;
    end else if (iosc_off) begin
      en.watch = sel.wt_src_hs;
    end
    if (src.halted && src.opt_stoppable) begin
      en.wdt = 1'b0;
    end
    if (iosc_off) begin
      en.clk_mon = 1'b0;
    end
  end

endmodule

//--- bench/hmcg_top_sva.sv
// port assertions of the halt mode controller
`timescale 1ns/1ps
module hmcg_top_sva #(
  parameter int PORT_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic halt_exec,
  input wire logic cpu_on_subclk,
  input wire logic hs_osc_run,
  input wire logic opt_iosc_soft_stop,
  input wire logic irq_unmasked,
  input wire logic irq_enable,
  input wire hmcg_pkg::hmcg_sel_type periph_sel,
  input wire logic cpu_clk_en,
  input wire logic halted,
  input wire logic [PORT_W-1:0] port_latch,
  input wire hmcg_pkg::hmcg_en_type periph_en,
  input wire logic vector_take,
  input wire logic resume_next,
  input wire logic reset_vector
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_sub; halted && cpu_on_subclk && !hs_osc_run; endsequence
  sequence s_wake; $rose(irq_unmasked) && halted; endsequence
  property p_gate; halt_exec && !halted |=> !cpu_clk_en && halted; endproperty
  a_gate: assert property (p_gate) else $error("cpu clock kept");
  property p_hold; halted |=> $stable(port_latch); endproperty
  a_hold: assert property (p_hold) else $error("port moved");
  property p_nv;
    s_wake ##0 !irq_enable |=> !cpu_clk_en [*2] ##1 resume_next && cpu_clk_en;
  endproperty
  a_nv: assert property (p_nv) else $error("short wake wrong");
  property p_vec; s_wake ##0 irq_enable |=> !cpu_clk_en [*8] ##1 vector_take;
  endproperty
  a_vec: assert property (p_vec) else $error("vector wake wrong");
  property p_rst; $fell(rst) |-> reset_vector && cpu_clk_en && !halted;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_off;
    s_sub |=> !periph_en.tmr16 &&
      periph_en.tmr_a == $past(periph_sel.ta_src_ext);
  endproperty
  a_off: assert property (p_off) else $error("timer gate wrong");
  property p_ser;
    s_sub |=> periph_en.csi == $past(periph_sel.csi_ext_clk) &&
      periph_en.uart_b == $past(periph_sel.uart_b_from_ta &
      periph_sel.ta_src_ext & periph_sel.ta_running);
  endproperty
  a_ser: assert property (p_ser) else $error("serial gate wrong");
  property p_wdt; halted && opt_iosc_soft_stop && !reset_vector |=> !periph_en.wdt;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog ran");
  sequence s_pulse; vector_take || resume_next; endsequence
  property p_one;
    s_pulse |-> (cpu_clk_en && !halted) ##1 (!vector_take && !resume_next);
  endproperty
  a_one: assert property (p_one) else $error("wake pulse wrong");
endmodule
bind hmcg_top hmcg_top_sva #(.PORT_W(PORT_W)) u_sva (.*);

//--- bench/hmcg_cpu_model.sv
// cpu core model counting executed instruction cycles
`timescale 1ns/1ps
module hmcg_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic cpu_clk_en,
  output logic [15:0] icount
);
  always_ff @(posedge clk) begin
    if (rst) icount <= '0;
    else if (cpu_clk_en) icount <= icount + 16'h0001;
  end
endmodule

//--- bench/tb_hmcg_top.sv
// self-checking bench for the halt mode controller
`timescale 1ns/1ps
module tb_hmcg_top;
  logic clk = 0, rst = 1, halt_exec = 0, cpu_on_subclk = 0, hs_osc_run = 0;
  logic opt_iosc_soft_stop = 0, sw_iosc_stop = 0, irq_unmasked = 0;
  logic irq_enable = 0, port_wr = 0, cpu_clk_en, halted, iosc_run, off, stp;
  logic vector_take, resume_next, reset_vector, e;
  logic [7:0] port_wr_data = 0, port_latch, pv;
  logic [15:0] icount, ic0;
  hmcg_pkg::hmcg_sel_type periph_sel = '0;
  hmcg_pkg::hmcg_en_type periph_en;
  logic q[$];
  int seed = 53, n_mismatch = 0, tests_run = 0, cyc = 0;
  hmcg_top dut (.*);
  hmcg_cpu_model cpu (.*);
  always #25 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      results;
    end
  end
  // wake pulses are matched in order against the queued kind
  always @(negedge clk) begin
    if (vector_take === 1'b1 || resume_next === 1'b1) begin
      e = q.pop_front();
      chk({vector_take, resume_next}, {e, !e});
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    for (int p = 0; p < 2; p++) begin
      rst = 1;
      opt_iosc_soft_stop = p[0];
      @(negedge clk);
      chk(reset_vector, 1);
      chk(port_latch, 0);
      rst = 0;
      repeat (2) @(negedge clk);
      for (int i = 0; i < 10; i++) begin
        {periph_sel, cpu_on_subclk, hs_osc_run, sw_iosc_stop, irq_enable} =
          11'($random(seed));
        port_wr_data = 8'($random(seed));
        pv = port_wr_data;
        port_wr = 1;
        @(negedge clk);
        port_wr = 0;
        halt_exec = 1;
        chk(port_latch, pv);
        @(negedge clk);
        halt_exec = 0;
        port_wr = 1;
        port_wr_data = ~pv;
        ic0 = icount;
        repeat (2) @(negedge clk);
        port_wr = 0;
        off = cpu_on_subclk & ~hs_osc_run;
        stp = opt_iosc_soft_stop & sw_iosc_stop;
        chk(port_latch, pv);
        chk(icount, ic0);
        chk(iosc_run, !stp);
        chk(periph_en.tmr16, !off);
        chk(periph_en.wdt, !opt_iosc_soft_stop);
        chk(periph_en.tmr_a, off ? periph_sel.ta_src_ext : 1'b1);
        chk(periph_en.csi, off ? periph_sel.csi_ext_clk : 1'b1);
        chk(periph_en.uart_a, off ? periph_sel.uart_a_from_ta &
          periph_sel.ta_src_ext & periph_sel.ta_running : 1'b1);
        chk(periph_en.clk_mon, !(cpu_on_subclk & stp));
        chk(periph_en.watch, off ? periph_sel.wt_src_sub :
          cpu_on_subclk & stp ? periph_sel.wt_src_hs : 1'b1);
        irq_unmasked = 1;
        q.push_back(irq_enable);
        @(negedge clk);
        irq_unmasked = 0;
        for (int k = 0; k < 12 && halted; k++) @(negedge clk);
        chk(halted, 0);
      end
    end
    @(negedge clk);
    chk(16'(q.size()), 0);
    results;
  end
endmodule
